//--- hw/cid_core.v
// Purpose: Decode and execute core for a 14-bit instruction set.
// Assumes: Program memory answers combinationally to progAddr.
// Notes: Execution happens on the last clock of each 4-clock cycle.
// What this block does
// - All file registers share one addressing path
// - Status flag updates override written value
// - Direction bit 3 always reads one
// - Low byte write loads latch into high
// - Low byte modify uses low byte, reloads high
// - Bit clear/set rewrite whole register
// - Byte ops: format, zero flag, swap none
// - Rotates go through carry, carry only
// - Counted skips write result, skip on zero
// - Skip-if-clear test on selected bit
// - Skip-if-set test on selected bit
// - Literal add/sub update carry, nibble, zero
// - Literal logic ops update zero only
// - Return with literal loads accumulator, two cycles
// - Standby and watchdog clear set timeout; standby clears powerdown, watchdog clear sets it
// - Port self-modify uses pin levels
// - Timer write clears assigned prescaler
// - Branch or true test adds nop cycle
// - Destination bit picks accumulator or file
// - Instruction cycle is four clocks
`timescale 1ns/1ps
`include "cid_core_consts.vh"
module cid_core #(
  parameter PINS = 6,
  parameter STACK_DEPTH = 8
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Program memory
  output reg [10:0] progAddr,
  input wire [13:0] instrWord,
  // Port pins
  input wire [PINS-1:0] pinIn,
  output reg [PINS-1:0] pinOut,
  output reg [PINS-1:0] pinOe,
  // Core events
  output reg standby,
  output reg gieOut,
  output reg wdtClear,
  // Control port
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata
);
  reg [1:0] phase;
  reg [7:0] acc;
  reg [7:0] status;
  reg [7:0] timer;
  reg [7:0] prescaler;
  reg [7:0] pc_high_holding_latch;
  reg [7:0] fileMem [0:127];
  reg [10:0] stack [0:STACK_DEPTH-1];
  reg [2:0] sp;
  reg nopCycle;
  reg nopAdvance;
  reg runEn;
  reg psaTimer;
  wire exec = runEn & ~standby & (phase == `CID_EXEC_PHASE);
  wire [1:0] grp = instrWord[13:12];
  wire [3:0] op = instrWord[11:8];
  wire dBit = instrWord[7];
  wire [6:0] fa = instrWord[6:0];
  wire [2:0] bsel = instrWord[9:7];
  wire [7:0] lit = instrWord[7:0];
  wire [2:0] spDown = sp - 3'h1;
  wire [10:0] pcInc = progAddr + 11'h001;
  // Operand fetch from any file address
  reg [7:0] operand;
  always @* begin
    case (fa)
      `CID_FA_TIMER: operand = timer;
      `CID_FA_PCL: operand = progAddr[7:0];
      `CID_FA_STATUS: operand = status;
      `CID_FA_DIR: operand = {{(8-PINS){1'b0}}, ~pinOe} | (8'h01 << `CID_DIR_IN_BIT);
      `CID_FA_PORT: operand = {{(8-PINS){1'b0}}, pinIn};
      `CID_FA_PC_HIGH_HOLDING_LATCH: operand = pc_high_holding_latch;
      7'h00: operand = 8'h00;
      default: operand = fileMem[fa];
    endcase
  end
  wire [7:0] opA = (grp == 2'b11) ? lit : operand;
  wire [8:0] addSum = {1'b0, opA} + {1'b0, acc};
  wire [4:0] addNib = {1'b0, opA[3:0]} + {1'b0, acc[3:0]};
  wire [8:0] subSum = {1'b0, opA} + {1'b0, ~acc} + 9'h001;
  wire [4:0] subNib = {1'b0, opA[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  wire [7:0] bitMask = 8'h01 << bsel;
  // Decode and ALU
  reg [7:0] res;
  reg wrAcc;
  reg wrFile;
  reg updZ;
  reg updC;
  reg updDC;
  reg newC;
  reg newDC;
  reg skip;
  reg branch;
  reg push;
  reg pop;
  reg retInt;
  reg goStandby;
  reg doWdClr;
  always @* begin
    res = 8'h00;
    wrAcc = 1'b0;
    wrFile = 1'b0;
    updZ = 1'b0;
    updC = 1'b0;
    updDC = 1'b0;
    newC = status[`CID_ST_C];
    newDC = status[`CID_ST_DC];
    skip = 1'b0;
    branch = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    retInt = 1'b0;
    goStandby = 1'b0;
    doWdClr = 1'b0;
    case (grp)
      2'b00: begin
        wrAcc = ~dBit;
        wrFile = dBit;
        updZ = (op >= 4'h1) && (op <= 4'hA);
        case (op)
          4'h0: begin
            wrAcc = 1'b0;
            res = acc;
            if (lit == `CID_ENC_RETURN) begin
              pop = 1'b1;
            end else if (lit == `CID_ENC_RETINT) begin
              pop = 1'b1;
              retInt = 1'b1;
            end else if (lit == `CID_ENC_STANDBY) begin
              goStandby = 1'b1;
            end else if (lit == `CID_ENC_WDCLR) begin
              doWdClr = 1'b1;
            end
          end
          4'h1: res = 8'h00;
          4'h2: begin
            res = subSum[7:0];
            newC = subSum[8];
            newDC = subNib[4];
            updC = 1'b1;
            updDC = 1'b1;
          end
          4'h3: res = operand - 8'h01;
          4'h4: res = operand | acc;
          4'h5: res = operand & acc;
          4'h6: res = operand ^ acc;
          4'h7: begin
            res = addSum[7:0];
            newC = addSum[8];
            newDC = addNib[4];
            updC = 1'b1;
            updDC = 1'b1;
          end
          4'h8: res = operand;
          4'h9: res = ~operand;
          4'hA: res = operand + 8'h01;
          4'hB: begin
            res = operand - 8'h01;
            skip = (res == 8'h00);
          end
          4'hC: begin
            res = {status[`CID_ST_C], operand[7:1]};
            newC = operand[0];
            updC = 1'b1;
          end
          4'hD: begin
            res = {operand[6:0], status[`CID_ST_C]};
            newC = operand[7];
            updC = 1'b1;
          end
          4'hE: res = {operand[3:0], operand[7:4]};
          default: begin
            res = operand + 8'h01;
            skip = (res == 8'h00);
          end
        endcase
      end
      2'b01: begin
        case (op[3:2])
          2'b00: begin
            res = operand & ~bitMask;
            wrFile = 1'b1;
          end
          2'b01: begin
            res = operand | bitMask;
            wrFile = 1'b1;
          end
          2'b10: skip = ~|(operand & bitMask);
          default: skip = |(operand & bitMask);
        endcase
      end
      2'b10: begin
        branch = 1'b1;
        push = ~instrWord[11];
      end
      default: begin
        wrAcc = 1'b1;
        case (op[3:2])
          2'b00: res = lit;
          2'b01: begin
            res = lit;
            pop = 1'b1;
          end
          2'b10: begin
            updZ = 1'b1;
            if (op[1:0] == 2'b00) begin
              res = lit | acc;
            end else if (op[1:0] == 2'b01) begin
              res = lit & acc;
            end else if (op[1:0] == 2'b10) begin
              res = lit ^ acc;
            end else begin
              wrAcc = 1'b0;
              updZ = 1'b0;
            end
          end
          default: begin
            res = op[1] ? addSum[7:0] : subSum[7:0];
            newC = op[1] ? addSum[8] : subSum[8];
            newDC = op[1] ? addNib[4] : subNib[4];
            updZ = 1'b1;
            updC = 1'b1;
            updDC = 1'b1;
          end
        endcase
      end
    endcase
  end
  wire fileWrite = exec & ~nopCycle & wrFile;
  wire pclWrite = wrFile & (fa == `CID_FA_PCL);
  // Status written by the instruction, then flags laid over it
  reg [7:0] next_status;
  always @* begin
    next_status = status;
    if (wrFile && fa == `CID_FA_STATUS) begin
      next_status[7:5] = res[7:5];
      next_status[2:0] = res[2:0];
    end
    if (updZ) begin
      next_status[`CID_ST_Z] = (res == 8'h00);
    end
    if (updC) begin
      next_status[`CID_ST_C] = newC;
    end
    if (updDC) begin
      next_status[`CID_ST_DC] = newDC;
    end
    if (goStandby) begin
      next_status[`CID_ST_TO] = 1'b1;
      next_status[`CID_ST_PD] = 1'b0;
    end
    if (doWdClr) begin
      next_status[`CID_ST_TO] = 1'b1;
      next_status[`CID_ST_PD] = 1'b1;
    end
  end
  // Phase counter, one instruction cycle per wrap
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  // Sequencing, accumulator, status and special registers
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      progAddr <= 11'h000;
      acc <= 8'h00;
      status <= `CID_STATUS_RST;
      timer <= 8'h00;
      prescaler <= 8'h00;
      pc_high_holding_latch <= 8'h00;
      sp <= 3'h0;
      nopCycle <= 1'b0;
      nopAdvance <= 1'b0;
      pinOut <= {PINS{1'b0}};
      pinOe <= {PINS{1'b0}};
      standby <= 1'b0;
      gieOut <= 1'b0;
      wdtClear <= 1'b0;
      runEn <= 1'b0;
      psaTimer <= 1'b0;
    end else begin
      wdtClear <= 1'b0;
      if (regWr && regAddr == `CID_RA_CTRL) begin
        runEn <= regWdata[`CID_CTRL_RUN];
        psaTimer <= regWdata[`CID_CTRL_PSA];
        if (regWdata[`CID_CTRL_WAKE]) begin
          standby <= 1'b0;
        end
      end
      if (exec) begin
        // Timer ticks once per cycle, through the prescaler if assigned
        if (fileWrite && fa == `CID_FA_TIMER) begin
          timer <= res;
          if (psaTimer) begin
            prescaler <= 8'h00;
          end
        end else if (!psaTimer || prescaler == 8'hFF) begin
          timer <= timer + 8'h01;
          prescaler <= 8'h00;
        end else begin
          prescaler <= prescaler + 8'h01;
        end
        if (nopCycle) begin
          nopCycle <= 1'b0;
          if (nopAdvance) begin
            progAddr <= pcInc;
          end
        end else begin
          status <= next_status;
          if (wrAcc) begin
            acc <= res;
          end
          if (fileWrite) begin
            case (fa)
              `CID_FA_PC_HIGH_HOLDING_LATCH: pc_high_holding_latch <= res;
              `CID_FA_PORT: pinOut <= res[PINS-1:0];
              `CID_FA_DIR: pinOe <= ~res[PINS-1:0] & ~({{(PINS-1){1'b0}}, 1'b1} << `CID_DIR_IN_BIT);
              default: ;
            endcase
          end
          progAddr <= pcInc;
          if (pclWrite) begin
            progAddr <= {pc_high_holding_latch[2:0], res};
            nopCycle <= 1'b1;
            nopAdvance <= 1'b0;
          end else if (branch) begin
            progAddr <= instrWord[10:0];
            nopCycle <= 1'b1;
            nopAdvance <= 1'b0;
          end else if (pop) begin
            progAddr <= stack[spDown];
            nopCycle <= 1'b1;
            nopAdvance <= 1'b0;
          end else if (skip) begin
            nopCycle <= 1'b1;
            nopAdvance <= 1'b1;
          end
          if (push) begin
            sp <= sp + 3'h1;
          end else if (pop) begin
            sp <= spDown;
          end
          if (retInt) begin
            gieOut <= 1'b1;
          end
          if (goStandby) begin
            standby <= 1'b1;
          end
          if (goStandby || doWdClr) begin
            wdtClear <= 1'b1;
          end
        end
      end
    end
  end
  // General registers and stack need no reset
  always @(posedge clock) begin
    if (fileWrite && fa > `CID_FA_PC_HIGH_HOLDING_LATCH) begin
      fileMem[fa] <= res;
    end
    if (exec && !nopCycle && push) begin
      stack[sp] <= pcInc;
    end
  end
  // Control port read, data valid one clock after the strobe
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        `CID_RA_CTRL: regRdata <= {5'h00, standby, psaTimer, runEn};
        `CID_RA_PCLO: regRdata <= progAddr[7:0];
        `CID_RA_PCHI: regRdata <= {5'h00, progAddr[10:8]};
        `CID_RA_ACC: regRdata <= acc;
        `CID_RA_STATUS: regRdata <= status;
        `CID_RA_TIMER: regRdata <= timer;
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

//--- hw/cid_core_consts.vh
// Purpose: Constants for the 14-bit instruction decoder core.
// Assumes: Included by cid_core.v only.
// Notes: Offsets are file addresses or control port indices.
`ifndef CID_CORE_CONSTS_VH
`define CID_CORE_CONSTS_VH
// Clocks per instruction cycle and phase of execution
`define CID_PHASES 4
`define CID_EXEC_PHASE 2'h3
// File addresses of special registers
`define CID_FA_TIMER 7'h01
`define CID_FA_PCL 7'h02
`define CID_FA_STATUS 7'h03
`define CID_FA_DIR 7'h05
`define CID_FA_PORT 7'h06
`define CID_FA_PC_HIGH_HOLDING_LATCH 7'h0A
// Status field positions and reset value
`define CID_ST_C 0
`define CID_ST_DC 1
`define CID_ST_Z 2
`define CID_ST_PD 3
`define CID_ST_TO 4
`define CID_STATUS_RST 8'h18
// Direction bit of the input-only pin
`define CID_DIR_IN_BIT 3
// Control port indices
`define CID_RA_CTRL 3'h0
`define CID_RA_PCLO 3'h1
`define CID_RA_PCHI 3'h2
`define CID_RA_ACC 3'h3
`define CID_RA_STATUS 3'h4
`define CID_RA_TIMER 3'h5
// Control register fields
`define CID_CTRL_RUN 0
`define CID_CTRL_PSA 1
`define CID_CTRL_WAKE 2
// Fixed control encodings in the low byte
`define CID_ENC_RETURN 8'h08
`define CID_ENC_RETINT 8'h09
`define CID_ENC_STANDBY 8'h63
`define CID_ENC_WDCLR 8'h64
`endif

//--- verif/cid_core_chk.sv
// Purpose: Port-level checker for the instruction decoder core.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Phase count mirrors the core's four-clock instruction cycle.
`timescale 1ns/1ps
module cid_core_chk #(
  parameter PINS = 6
) (
  input wire clock,
  input wire reset_n,
  input wire [10:0] progAddr,
  input wire [PINS-1:0] pinOe,
  input wire standby,
  input wire gieOut,
  input wire wdtClear,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdata
);
  logic [1:0] phase;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_rdata_idle;
    !$past(regRd) |-> regRdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_ctrl_read;
    regRd && regAddr == 3'h0 |=> regRdata[2] == $past(standby);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("standby readback wrong");
  // Program address may only move on the execute edge of a cycle
  property p_pc_phase;
    $changed(progAddr) |-> phase == 2'h0;
  endproperty
  a_pc_phase: assert property (p_pc_phase) else $error("pc moved off phase");
  property p_wdt_pulse;
    wdtClear |-> phase == 2'h0 ##1 !wdtClear;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse wrong");
  property p_oe_bit3;
    pinOe[3] == 1'b0;
  endproperty
  a_oe_bit3: assert property (p_oe_bit3) else $error("input pin driven");
  property p_wake;
    standby && regWr && regAddr == 3'h0 && regWdata[2] |=> !standby;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_standby_hold;
    standby && !regWr |=> $stable(progAddr) && standby;
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("ran in standby");
  property p_gie_hold;
    gieOut |=> gieOut;
  endproperty
  a_gie_hold: assert property (p_gie_hold) else $error("enable dropped");
  c_wdt: cover property (wdtClear);
  c_standby: cover property ($rose(standby));
  c_gie: cover property ($rose(gieOut));
endmodule
bind cid_core cid_core_chk #(.PINS(PINS)) u_cid_core_chk (.clock(clock), .reset_n(reset_n),
  .progAddr(progAddr), .pinOe(pinOe), .standby(standby), .gieOut(gieOut),
  .wdtClear(wdtClear), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata));

//--- verif/cid_core_bench.sv
// Purpose: Program-driven test of the instruction decoder core.
// Assumes: Program memory modelled here, one word per progAddr.
// Notes: Each program ends in a jump to itself, so a fixed wait suffices.
`timescale 1ns/1ps
module cid_core_bench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [10:0] progAddr;
  logic [13:0] instrWord = 14'h0000;
  logic [5:0] pinIn = 6'h21;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic standby;
  logic gieOut;
  logic wdtClear;
  logic [5:0] pinOut;
  logic [5:0] pinOe;
  logic [13:0] mem [0:2047];
  int wdtCount = 0;
  int bad_count = 0;
  int comparisons = 0;
  always #10 clock = ~clock;
  // Registered fetch; the word settles long before the next execute edge
  always @(posedge clock) begin
    instrWord <= mem[progAddr];
  end
  // Watchdog clear is a one-clock pulse, so count it rather than sample it
  always @(posedge clock) begin
    if (wdtClear) begin
      wdtCount <= wdtCount + 1;
    end
  end
  cid_core #(.PINS(6), .STACK_DEPTH(8)) u_cid_core (.clock(clock), .reset_n(reset_n),
    .progAddr(progAddr), .instrWord(instrWord), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .standby(standby), .gieOut(gieOut), .wdtClear(wdtClear), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  task test_done;
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string name);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] exp, input string name);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp, name);
  endtask
  task ld(input logic [13:0] w[$]);
    foreach (mem[i]) mem[i] = 14'h0000;
    foreach (w[i]) mem[i] = w[i];
  endtask
  // Reset, confirm status reset value, start execution and let it settle
  task go;
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rd(3'h4, 8'h18, "status");
    wr(3'h0, 8'h01);
    repeat (200) @(posedge clock);
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    test_done;
  end
  initial begin
    // Literal arithmetic and logic, flags accumulate across ops
    ld({14'h300F, 14'h3E01, 14'h00A0, 14'h3C30, 14'h3A20, 14'h2805});
    go;
    rd(3'h3, 8'h00, "acc");
    rd(3'h4, 8'h1F, "status");
    // Counted skip and both bit tests
    ld({14'h3001, 14'h00A0, 14'h0BA0, 14'h3055, 14'h1C20, 14'h3066, 14'h1820,
        14'h3077, 14'h2808});
    go;
    rd(3'h3, 8'h66, "acc");
    rd(3'h4, 8'h18, "status");
    rd(3'h1, 8'h08, "pclo");
    // Rotate, swap, bit set, move with zero flag
    ld({14'h3081, 14'h00A0, 14'h0D20, 14'h0E20, 14'h14A0, 14'h0820, 14'h2806});
    go;
    rd(3'h3, 8'h83, "acc");
    rd(3'h4, 8'h19, "status");
    // Direction bit 3 readback plus port read from pins
    ld({14'h0185, 14'h0805, 14'h00A1, 14'h0806, 14'h393F, 14'h0721, 14'h2806});
    go;
    rd(3'h3, 8'h29, "acc");
    chk({2'b00, pinOe}, 8'h37, "pinoe");
    // Low byte write pulls in high latch, then call and both returns
    ld({14'h3002, 14'h008A, 14'h3005, 14'h0082});
    mem[11'h205] = 14'h2210;
    mem[11'h206] = 14'h2211;
    mem[11'h207] = 14'h2A07;
    mem[11'h210] = 14'h3477;
    mem[11'h211] = 14'h0009;
    go;
    rd(3'h1, 8'h07, "pclo");
    rd(3'h2, 8'h02, "pchi");
    rd(3'h3, 8'h77, "acc");
    chk({7'h00, gieOut}, 8'h01, "gie");
    // Watchdog clear then standby, wake through the control port
    wdtCount = 0;
    ld({14'h0064, 14'h0063, 14'h3042, 14'h2803});
    go;
    rd(3'h0, 8'h05, "ctrl");
    rd(3'h4, 8'h10, "status");
    rd(3'h3, 8'h00, "acc");
    wr(3'h0, 8'h05);
    repeat (40) @(posedge clock);
    rd(3'h3, 8'h42, "acc");
    rd(3'h0, 8'h01, "ctrl");
    chk(wdtCount[7:0], 8'h02, "wdtclear");
    // Timer write late in the prescale count; an uncleared prescaler ticks soon after
    ld({14'h3050, 14'h00A0, 14'h0BA0, 14'h2802, 14'h30A5, 14'h0081, 14'h2806});
    go;
    wr(3'h0, 8'h03);
    repeat (1200) @(posedge clock);
    rd(3'h5, 8'hA5, "timer");
    // Computed jump on low byte, port self-modify from pins, status clear
    ld({14'h3002, 14'h0782, 14'h0185, 14'h303C, 14'h0086, 14'h0A86, 14'h0100, 14'h1403,
        14'h0183, 14'h2809});
    go;
    rd(3'h4, 8'h1C, "status");
    rd(3'h3, 8'h00, "acc");
    rd(3'h1, 8'h09, "pclo");
    chk({2'b00, pinOut}, 8'h22, "pinout");
    chk({2'b00, pinOe}, 8'h00, "pinoe");
    test_done;
  end
endmodule
